// file: inc/bcri_defines.svh
// bcri_defines.svh: offsets, command codes, field values and reset values
// of the breaker command register interpreter.
// assumes: included by bare name from the package, the rtl files except bcri_pw_check, and the bench.
`ifndef BCRI_DEFINES_SVH
`define BCRI_DEFINES_SVH

// command window, holding-register addresses
`define BCRI_ADDR_CODE      16'h1F3F
`define BCRI_ADDR_COUNT     16'h1F40
`define BCRI_ADDR_DEST      16'h1F41
`define BCRI_ADDR_SECURITY  16'h1F42
`define BCRI_ADDR_PW_HI     16'h1F43
`define BCRI_ADDR_PW_LO     16'h1F44
`define BCRI_ADDR_PARAM0    16'h1F45
`define BCRI_ADDR_PARAM1    16'h1F46

// response area
`define BCRI_ADDR_RSP_CODE   16'h1F53
`define BCRI_ADDR_RSP_STATUS 16'h1F54
`define BCRI_ADDR_RSP_BYTES  16'h1F55

// command codes
`define BCRI_CODE_ENERGY_MODE 16'hB88A
`define BCRI_CODE_CUR_DEMAND  16'hB88B
`define BCRI_CODE_PWR_DEMAND  16'hB88C
`define BCRI_CODE_OPEN        16'h0388
`define BCRI_CODE_CLOSE       16'h0389
`define BCRI_CODE_CLOSE_INHIB 16'h038E

// parameter counts
`define BCRI_COUNT_10 16'h000A
`define BCRI_COUNT_12 16'h000C
`define BCRI_COUNT_13 16'h000D
`define BCRI_COUNT_14 16'h000E

// fixed header values and field ranges
`define BCRI_DEST_VALUE     16'h1501
`define BCRI_SECURITY_PW    16'h0001
`define BCRI_INTERVAL_MIN   16'h0001
`define BCRI_INTERVAL_MAX   16'h003C
`define BCRI_METHOD_SLIDING 16'h0000
`define BCRI_ORIGIN_REMOTE  16'h0001
`define BCRI_FLAG_MAX       16'h0001

// words of the window that each command needs written before it runs
`define BCRI_NEED_HEADER 8'h1F
`define BCRI_NEED_P0     8'h3F
`define BCRI_NEED_P1     8'h7F

// reset values and the data byte count of set responses
`define BCRI_ENERGY_RESET  1'b0
`define BCRI_INHIBIT_RESET 1'b0
`define BCRI_RSP_BYTES_SET 16'h0000

`endif

// file: inc/bcri_pkg.sv
// bcri_pkg: types of the breaker command register interpreter.
// assumes: bcri_defines.svh on the include path.
`include "bcri_defines.svh"

package bcri_pkg;

    // command status reported in the response area, 0 is success
    typedef enum logic [15:0] {
        BCRI_ST_OK           = 16'h0000,
        BCRI_ST_BAD_CODE     = 16'h0001,
        BCRI_ST_BAD_COUNT    = 16'h0002,
        BCRI_ST_BAD_DEST     = 16'h0003,
        BCRI_ST_BAD_SECURITY = 16'h0004,
        BCRI_ST_BAD_PASSWORD = 16'h0005,
        BCRI_ST_BAD_PARAM    = 16'h0006,
        BCRI_ST_INHIBITED    = 16'h0007
    } bcri_status_e;

    // whole state of the interpreter top
    typedef struct packed {
        logic [15:0] code;
        logic [15:0] count;
        logic [15:0] dest;
        logic [15:0] security;
        logic [15:0] pw_hi;
        logic [15:0] pw_lo;
        logic [15:0] param0;
        logic [15:0] param1;
        logic [7:0]  written;
        logic [15:0] rsp_code;
        logic [15:0] rsp_status;
        logic [15:0] rsp_bytes;
        logic        energy_signed;
        logic [5:0]  cur_interval;
        logic [5:0]  pwr_interval;
        logic        close_inhibit;
        logic        open_pulse;
        logic        close_pulse;
        logic        cmd_done;
        logic [15:0] rdata;
        logic        rvalid;
    } bcri_state_s;

endpackage : bcri_pkg

// file: rtl/bcri_pw_check.sv
// bcri_pw_check: compares the two password words with the profiles.
// assumes: purely combinational, inputs are registered by the caller.
`timescale 1ns/1ps
`default_nettype none

module bcri_pw_check #(
    parameter logic [31:0] ADMIN_PASSWORD    = 32'h0000_0001,
    parameter logic [31:0] OPERATOR_PASSWORD = 32'h0000_0002
) (
    input  wire logic [15:0] pw_hi,
    input  wire logic [15:0] pw_lo,
    output logic             admin_ok,
    output logic             operator_ok
);
    import bcri_pkg::*;

    // high word sits at the lower address of the octet string
    assign admin_ok    = ({pw_hi, pw_lo} == ADMIN_PASSWORD);
    assign operator_ok = ({pw_hi, pw_lo} == OPERATOR_PASSWORD);

endmodule : bcri_pw_check

`default_nettype wire

// file: rtl/bcri_validate.sv
// bcri_validate: decodes the command code and checks the command block.
// assumes: combinational; block fields come from the caller's registers.
`timescale 1ns/1ps
`default_nettype none
`include "bcri_defines.svh"

module bcri_validate (
    input  wire logic [15:0]         code,
    input  wire logic [15:0]         count,
    input  wire logic [15:0]         dest,
    input  wire logic [15:0]         security,
    input  wire logic [15:0]         param0,
    input  wire logic [15:0]         param1,
    input  wire logic                admin_ok,
    input  wire logic                operator_ok,
    input  wire logic                close_inhibit,
    output bcri_pkg::bcri_status_e   status,
    output logic [7:0]               need_mask
);
    import bcri_pkg::*;

    logic [15:0] exp_count;
    logic        known;
    logic        admin_only;
    logic        param_ok;
    logic        inhibited;

    // per-code expectations: count, words needed, profile, parameter range
    always_comb begin
        exp_count  = `BCRI_COUNT_10;
        known      = 1'b1;
        admin_only = 1'b1;
        param_ok   = 1'b1;
        inhibited  = 1'b0;
        need_mask  = `BCRI_NEED_HEADER;
        case (code)
            `BCRI_CODE_ENERGY_MODE: begin
                exp_count = `BCRI_COUNT_12;
                need_mask = `BCRI_NEED_P0;
                param_ok  = (param0 <= `BCRI_FLAG_MAX);
            end
            `BCRI_CODE_CUR_DEMAND: begin
                exp_count = `BCRI_COUNT_12;
                need_mask = `BCRI_NEED_P0;
                param_ok  = (param0 >= `BCRI_INTERVAL_MIN) &&
                            (param0 <= `BCRI_INTERVAL_MAX);
            end
            `BCRI_CODE_PWR_DEMAND: begin
                exp_count = `BCRI_COUNT_14;
                need_mask = `BCRI_NEED_P1;
                param_ok  = (param0 == `BCRI_METHOD_SLIDING) &&
                            (param1 >= `BCRI_INTERVAL_MIN) &&
                            (param1 <= `BCRI_INTERVAL_MAX);
            end
            `BCRI_CODE_OPEN: begin
                exp_count  = `BCRI_COUNT_10;
                admin_only = 1'b0;
            end
            `BCRI_CODE_CLOSE: begin
                exp_count  = `BCRI_COUNT_10;
                admin_only = 1'b0;
                inhibited  = close_inhibit;
            end
            `BCRI_CODE_CLOSE_INHIB: begin
                exp_count  = `BCRI_COUNT_13;
                admin_only = 1'b0;
                need_mask  = `BCRI_NEED_P1;
                param_ok   = (param0 <= `BCRI_FLAG_MAX) &&
                             (param1 == `BCRI_ORIGIN_REMOTE);
            end
            default: begin
                known = 1'b0;
            end
        endcase
    end

    // first failing check decides the reported status
    always_comb begin
        if (!known) begin
            status = BCRI_ST_BAD_CODE;
        end else if (count != exp_count) begin
            status = BCRI_ST_BAD_COUNT;
        end else if (dest != `BCRI_DEST_VALUE) begin
            status = BCRI_ST_BAD_DEST;
        end else if (security != `BCRI_SECURITY_PW) begin
            status = BCRI_ST_BAD_SECURITY;
        end else if (!(admin_ok || (!admin_only && operator_ok))) begin
            status = BCRI_ST_BAD_PASSWORD;
        end else if (!param_ok) begin
            status = BCRI_ST_BAD_PARAM;
        end else if (inhibited) begin
            status = BCRI_ST_INHIBITED;
        end else begin
            status = BCRI_ST_OK;
        end
    end

endmodule : bcri_validate

`default_nettype wire

// file: rtl/bcri_top.sv
// bcri_top: command-register interpreter of a breaker communication
// interface; holding registers in, settings and breaker orders out.
// assumes: one holding-register access per cycle from the protocol layer,
// all inputs synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "bcri_defines.svh"

module bcri_top #(
    parameter logic [31:0] ADMIN_PASSWORD       = 32'h0000_0001,
    parameter logic [31:0] OPERATOR_PASSWORD    = 32'h0000_0002,
    parameter logic [5:0]  DEF_CURRENT_INTERVAL = 6'h0F,
    parameter logic [5:0]  DEF_POWER_INTERVAL   = 6'h0F
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic             reg_rvalid,
    output logic             energy_mode_signed,
    output logic [5:0]       current_demand_interval,
    output logic [5:0]       power_demand_interval,
    output logic             close_inhibited,
    output logic             breaker_open_order,
    output logic             breaker_close_order,
    output logic             cmd_done
);
    import bcri_pkg::*;

    // constant reset image; settings start at their factory values
    localparam bcri_state_s RESET_STATE = '{
        energy_signed: `BCRI_ENERGY_RESET,
        cur_interval:  DEF_CURRENT_INTERVAL,
        pwr_interval:  DEF_POWER_INTERVAL,
        close_inhibit: `BCRI_INHIBIT_RESET,
        default:       '0
    };

    bcri_state_s  state_reg;
    bcri_state_s  state_next;
    logic         admin_ok;
    logic         operator_ok;
    bcri_status_e status;
    logic [7:0]   need_mask;
    logic         fire;

    // password profiles, checked against the stored block
    bcri_pw_check #(
        .ADMIN_PASSWORD    (ADMIN_PASSWORD),
        .OPERATOR_PASSWORD (OPERATOR_PASSWORD)
    ) u_pw_check (
        .pw_hi       (state_reg.pw_hi),
        .pw_lo       (state_reg.pw_lo),
        .admin_ok    (admin_ok),
        .operator_ok (operator_ok)
    );

    // command decode and block checks
    bcri_validate u_validate (
        .code          (state_reg.code),
        .count         (state_reg.count),
        .dest          (state_reg.dest),
        .security      (state_reg.security),
        .param0        (state_reg.param0),
        .param1        (state_reg.param1),
        .admin_ok      (admin_ok),
        .operator_ok   (operator_ok),
        .close_inhibit (state_reg.close_inhibit),
        .status        (status),
        .need_mask     (need_mask)
    );

    // run once the code word and every word the code needs, except the high password word, are written;
    // the mask is built from writes since the last run, so a stale
    // parameter from an earlier block never completes a new one
    assign fire = state_reg.written[0] &&
                  ((state_reg.written & need_mask) == need_mask);

    // next-state logic: execution, then register writes, then reads
    always_comb begin
        state_next             = state_reg;
        state_next.open_pulse  = 1'b0;
        state_next.close_pulse = 1'b0;
        state_next.cmd_done    = 1'b0;
        state_next.rvalid      = 1'b0;

        // execution uses the stored block, one cycle after it completed
        if (fire) begin
            state_next.written    = 8'h00;
            state_next.rsp_code   = state_reg.code;
            state_next.rsp_status = status;
            // set commands return no data bytes
            state_next.rsp_bytes  = `BCRI_RSP_BYTES_SET;
            state_next.cmd_done   = 1'b1;
            if (status == BCRI_ST_OK) begin
                case (state_reg.code)
                    `BCRI_CODE_ENERGY_MODE: begin
                        state_next.energy_signed =
                            state_reg.param0[0];
                    end
                    `BCRI_CODE_CUR_DEMAND: begin
                        state_next.cur_interval =
                            state_reg.param0[5:0];
                    end
                    `BCRI_CODE_PWR_DEMAND: begin
                        state_next.pwr_interval =
                            state_reg.param1[5:0];
                    end
                    `BCRI_CODE_OPEN: begin
                        state_next.open_pulse = 1'b1;
                    end
                    `BCRI_CODE_CLOSE: begin
                        state_next.close_pulse = 1'b1;
                    end
                    `BCRI_CODE_CLOSE_INHIB: begin
                        state_next.close_inhibit =
                            state_reg.param0[0];
                    end
                    default: begin
                        state_next.cmd_done = 1'b1;
                    end
                endcase
            end
        end

        // holding-register writes; a write in the firing cycle is kept,
        // its written bit starts the next block instead of being lost
        if (reg_wr) begin
            if (reg_addr == `BCRI_ADDR_CODE) begin
                state_next.code       = reg_wdata;
                state_next.written[0] = 1'b1;
            end else if (reg_addr == `BCRI_ADDR_COUNT) begin
                state_next.count      = reg_wdata;
                state_next.written[1] = 1'b1;
            end else if (reg_addr == `BCRI_ADDR_DEST) begin
                state_next.dest       = reg_wdata;
                state_next.written[2] = 1'b1;
            end else if (reg_addr == `BCRI_ADDR_SECURITY) begin
                state_next.security   = reg_wdata;
                state_next.written[3] = 1'b1;
            end else if (reg_addr == `BCRI_ADDR_PW_HI) begin
                state_next.pw_hi      = reg_wdata;
                state_next.written[4] = 1'b0 | state_next.written[4];
            end else if (reg_addr == `BCRI_ADDR_PW_LO) begin
                // only the low password word sets the password entry of the mask
                state_next.pw_lo      = reg_wdata;
                state_next.written[4] = 1'b1;
            end else if (reg_addr == `BCRI_ADDR_PARAM0) begin
                state_next.param0     = reg_wdata;
                state_next.written[5] = 1'b1;
            end else if (reg_addr == `BCRI_ADDR_PARAM1) begin
                state_next.param1     = reg_wdata;
                state_next.written[6] = 1'b1;
            end else begin
                // response area is read-only, other addresses ignored
                state_next.written = state_next.written;
            end
        end

        // reads answer one cycle later; unmapped addresses read zero
        if (reg_rd) begin
            state_next.rvalid = 1'b1;
            if (reg_addr == `BCRI_ADDR_CODE) begin
                state_next.rdata = state_reg.code;
            end else if (reg_addr == `BCRI_ADDR_COUNT) begin
                state_next.rdata = state_reg.count;
            end else if (reg_addr == `BCRI_ADDR_DEST) begin
                state_next.rdata = state_reg.dest;
            end else if (reg_addr == `BCRI_ADDR_SECURITY) begin
                state_next.rdata = state_reg.security;
            end else if (reg_addr == `BCRI_ADDR_PW_HI) begin
                state_next.rdata = state_reg.pw_hi;
            end else if (reg_addr == `BCRI_ADDR_PW_LO) begin
                state_next.rdata = state_reg.pw_lo;
            end else if (reg_addr == `BCRI_ADDR_PARAM0) begin
                state_next.rdata = state_reg.param0;
            end else if (reg_addr == `BCRI_ADDR_PARAM1) begin
                state_next.rdata = state_reg.param1;
            end else if (reg_addr == `BCRI_ADDR_RSP_CODE) begin
                state_next.rdata = state_reg.rsp_code;
            end else if (reg_addr == `BCRI_ADDR_RSP_STATUS) begin
                state_next.rdata = state_reg.rsp_status;
            end else if (reg_addr == `BCRI_ADDR_RSP_BYTES) begin
                state_next.rdata = state_reg.rsp_bytes;
            end else begin
                state_next.rdata = 16'h0000;
            end
        end
    end

    // single state register, synchronous reset to the constant image
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // every output is a field of the state register
    assign reg_rdata               = state_reg.rdata;
    assign reg_rvalid              = state_reg.rvalid;
    assign energy_mode_signed      = state_reg.energy_signed;
    assign current_demand_interval = state_reg.cur_interval;
    assign power_demand_interval   = state_reg.pwr_interval;
    assign close_inhibited         = state_reg.close_inhibit;
    // one-cycle orders; breaker position is confirmed elsewhere
    assign breaker_open_order      = state_reg.open_pulse;
    assign breaker_close_order     = state_reg.close_pulse;
    assign cmd_done                = state_reg.cmd_done;

endmodule : bcri_top

`default_nettype wire

// file: bench/bcri_top_assertions.sv
// bcri_top_assertions: port timing relations of bcri_top.
// assumes: bound to bcri_top, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module bcri_top_assertions (
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       reg_rvalid,
    input wire logic       energy_mode_signed,
    input wire logic [5:0] current_demand_interval,
    input wire logic [5:0] power_demand_interval,
    input wire logic       close_inhibited,
    input wire logic       breaker_open_order,
    input wire logic       breaker_close_order,
    input wire logic       cmd_done
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // read answers follow their strobe; orders and settings are tied to an executed block
    property p_rd; reg_rvalid == $past(reg_rd); endproperty
    a_rd: assert property (p_rd)
        else $error("read answer not one cycle after strobe");
    property p_open; breaker_open_order |-> cmd_done && !breaker_close_order;
    endproperty
    a_open: assert property (p_open)
        else $error("open order outside execution");
    property p_cls; breaker_close_order |-> cmd_done && !close_inhibited;
    endproperty
    a_cls: assert property (p_cls)
        else $error("close order while inhibited");
    // a block takes at least five writes, so executions are spaced
    property p_gap; cmd_done |=> !cmd_done [*4]; endproperty
    a_gap: assert property (p_gap)
        else $error("executions too close");
    property p_cause; cmd_done |-> $past(reg_wr, 2); endproperty
    a_cause: assert property (p_cause)
        else $error("execution without completing write");
    property p_inh; $changed(close_inhibited) |-> cmd_done; endproperty
    a_inh: assert property (p_inh)
        else $error("inhibit changed without command");
    property p_eng; $changed(energy_mode_signed) |-> cmd_done; endproperty
    a_eng: assert property (p_eng)
        else $error("energy mode changed without command");
    property p_cur; $changed(current_demand_interval) |-> cmd_done &&
        current_demand_interval inside {[1:60]}; endproperty
    a_cur: assert property (p_cur)
        else $error("current interval bad update");
    property p_pwr; $changed(power_demand_interval) |-> cmd_done &&
        power_demand_interval inside {[1:60]}; endproperty
    a_pwr: assert property (p_pwr)
        else $error("power interval bad update");

    c_open: cover property (breaker_open_order);
    c_close: cover property (breaker_close_order);
    c_inh: cover property ($rose(close_inhibited));
endmodule : bcri_top_assertions

bind bcri_top bcri_top_assertions i_chk (.sys_clk, .reset, .reg_wr, .reg_rd,
    .reg_rvalid, .energy_mode_signed, .current_demand_interval,
    .power_demand_interval, .close_inhibited, .breaker_open_order,
    .breaker_close_order, .cmd_done);

`default_nettype wire

// file: bench/bcri_master_model.sv
// bcri_master_model: network master writing command blocks.
// assumes: strobes change just after rising edges, one access a cycle.
`timescale 1ns/1ps
`default_nettype none
`include "bcri_defines.svh"

module bcri_master_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid,
    output logic [15:0]      reg_addr,
    output logic             reg_wr,
    output logic [15:0]      reg_wdata,
    output logic             reg_rd
);
    initial begin
        reg_addr  = 16'h0000;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd    = 1'b0;
    end

    // back to back writes hold the strobe high
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask : wr

    // released lines flip so stale data never looks held
    task automatic idle();
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_wdata <= ~reg_wdata;
        reg_addr  <= ~reg_addr;
    endtask : idle

    // strobe stands for the one taken edge; the one-cycle answer is
    // read just after that edge, while rvalid still stands
    task automatic rd(input logic [15:0] a, output logic [15:0] d,
                      output logic v);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd

    // parameters go before the password, whose low word completes it
    task automatic send(input int c, n, d, s, input logic [31:0] pw,
                        input int p0, p1, np);
        wr(`BCRI_ADDR_CODE, 16'(c));
        wr(`BCRI_ADDR_COUNT, 16'(n));
        wr(`BCRI_ADDR_DEST, 16'(d));
        wr(`BCRI_ADDR_SECURITY, 16'(s));
        if (np > 0) wr(`BCRI_ADDR_PARAM0, 16'(p0));
        if (np > 1) wr(`BCRI_ADDR_PARAM1, 16'(p1));
        wr(`BCRI_ADDR_PW_HI, pw[31:16]);
        wr(`BCRI_ADDR_PW_LO, pw[15:0]);
        idle();
    endtask : send
endmodule : bcri_master_model

`default_nettype wire

// file: bench/breaker_command_register_interpreter_bench.sv
// bench: reference model of the command window checked at every result.
// assumes: bcri_top, bcri_master_model and the checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "bcri_defines.svh"

module breaker_command_register_interpreter_bench;
    localparam logic [31:0] ADM = 32'h0000_0001;
    localparam logic [31:0] OPR = 32'h0000_0002;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    wire logic [15:0] reg_addr, reg_wdata, reg_rdata;
    wire logic [5:0] current_demand_interval, power_demand_interval;
    wire logic reg_wr, reg_rd, reg_rvalid, energy_mode_signed, cmd_done;
    wire logic close_inhibited, breaker_open_order, breaker_close_order;
    int err_total, n_compared, e_sig, e_cur, e_pwr, e_inh, l_c, l_st;
    int codes[7] = '{47242, 47243, 47244, 904, 905, 910, 51329};

    bcri_top #(.ADMIN_PASSWORD(ADM), .OPERATOR_PASSWORD(OPR)) i_dut (
        .sys_clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_rvalid, .energy_mode_signed,
        .current_demand_interval, .power_demand_interval, .close_inhibited,
        .breaker_open_order, .breaker_close_order, .cmd_done);
    bcri_master_model i_master (.sys_clk, .reg_rdata, .reg_rvalid,
        .reg_addr, .reg_wr, .reg_wdata, .reg_rd);

    always #5 sys_clk = ~sys_clk;

    task automatic check(input string nm, input int ex, input logic [15:0] g);
        n_compared++;
        if (g !== 16'(ex)) begin
            err_total++;
            $display("wrong value %s expected %0d seen %0d", nm, ex, g);
        end
    endtask : check

    task automatic rdc(input logic [15:0] a, input string nm, input int ex);
        logic [15:0] d;
        logic        v;
        i_master.rd(a, d, v);
        check("rvalid", 1, 16'(v));
        check(nm, ex, d);
    endtask : rdc

    function automatic int need(input int c);
        return (c == 47242 || c == 47243) ? 12 : (c == 47244) ? 14 :
               (c == 910) ? 13 : 10;
    endfunction : need

    // status of a block and the settings it leaves behind
    function automatic int model(input int c, n, d, s, input logic [31:0] pw,
                                 input int p0, p1);
        if (!(c inside {47242, 47243, 47244, 904, 905, 910})) return 1;
        if (n != need(c)) return 2;
        if (d != 5377) return 3;
        if (s != 1) return 4;
        if (pw != ADM && !(c < 1000 && pw == OPR)) return 5;
        if ((c == 47242 && p0 > 1) || (c == 47243 && !(p0 inside {[1:60]}))
            || (c == 47244 && (p0 != 0 || !(p1 inside {[1:60]})))
            || (c == 910 && (p0 > 1 || p1 != 1))) return 6;
        if (c == 905 && e_inh == 1) return 7;
        if (c == 47242) e_sig = p0;
        if (c == 47243) e_cur = p0;
        if (c == 47244) e_pwr = p1;
        if (c == 910) e_inh = p0;
        return 0;
    endfunction : model

    task automatic run(input int c, n, d, s, input logic [31:0] pw,
                       input int p0, p1);
        int np;
        np = (c == 47242 || c == 47243) ? 1 : (c == 47244 || c == 910);
        np = (c == 47244 || c == 910) ? 2 : np;
        l_st = model(c, n, d, s, pw, p0, p1);
        l_c = c;
        i_master.send(c, n, d, s, pw, p0, p1, np);
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            #1;
            if (cmd_done === 1'b1) break;
        end
        check("cmd_done", 1, 16'(cmd_done));
        check("open", l_st == 0 && c == 904, 16'(breaker_open_order));
        check("close", l_st == 0 && c == 905, 16'(breaker_close_order));
        rdc(`BCRI_ADDR_RSP_STATUS, "status", l_st);
        rdc(`BCRI_ADDR_RSP_CODE, "last code", c);
        rdc(`BCRI_ADDR_RSP_BYTES, "bytes", 0);
        check("energy", e_sig, 16'(energy_mode_signed));
        check("cur", e_cur, 16'(current_demand_interval));
        check("pwr", e_pwr, 16'(power_demand_interval));
        check("inhibit", e_inh, 16'(close_inhibited));
    endtask : run

    task automatic test_done();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // watchdog well past the expected thousand or so cycles
    initial begin
        #200000;
        err_total++;
        test_done();
    end

    // directed corners, then random blocks, then a mid-run reset
    initial begin
        int c;
        int r;
        void'($urandom(82));
        {e_sig, e_inh, e_cur, e_pwr} = {32'd0, 32'd0, 32'd15, 32'd15};
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        run(47242, 12, 5377, 1, ADM, 1, 0);
        run(47243, 12, 5377, 1, ADM, 60, 0);
        run(47243, 12, 5377, 1, ADM, 0, 0);
        run(47244, 14, 5377, 1, ADM, 0, 1);
        run(47244, 14, 5377, 1, ADM, 1, 30);
        run(47242, 12, 5377, 1, OPR, 0, 0);
        run(910, 13, 5377, 1, OPR, 1, 1);
        run(905, 10, 5377, 1, ADM, 0, 0);
        run(910, 13, 5377, 1, ADM, 0, 2);
        run(910, 13, 5377, 1, ADM, 0, 1);
        run(905, 10, 5377, 1, OPR, 0, 0);
        run(904, 10, 5377, 1, OPR, 0, 0);
        run(904, 10, 5376, 1, ADM, 0, 0);
        run(904, 10, 5377, 0, ADM, 0, 0);
        run(904, 12, 5377, 1, ADM, 0, 0);
        run(905, 10, 5377, 1, ADM, 0, 0);
        i_master.wr(`BCRI_ADDR_RSP_STATUS, 16'hFFFF);
        i_master.idle();
        rdc(`BCRI_ADDR_RSP_STATUS, "status ro", l_st);
        rdc(`BCRI_ADDR_CODE, "code reg", l_c);
        rdc(16'h2000, "unmapped", 0);
        for (int i = 0; i < 60; i++) begin
            c = codes[$urandom % 7];
            r = $urandom % 4;
            run(c, need(c) + ($urandom % 8 == 0), 5377 - ($urandom % 9 == 0),
                1 - ($urandom % 9 == 0), r == 0 ? ADM : r == 1 ? OPR : $urandom,
                $urandom % 64, $urandom % 64);
        end
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("rst energy", 0, 16'(energy_mode_signed));
        check("rst cur", 15, 16'(current_demand_interval));
        check("rst pwr", 15, 16'(power_demand_interval));
        check("rst inhibit", 0, 16'(close_inhibited));
        test_done();
    end
endmodule : breaker_command_register_interpreter_bench

`default_nettype wire
